// *** cid_pkg.sv ***
// Package: register map, field layout and constants of the chip identity block
package cid_pkg;

   // Register byte offsets (no offsets printed; chosen locally)
   localparam logic [11:0] CID_OFS_IDENT   = 12'h000;
   localparam logic [11:0] CID_OFS_EXTID   = 12'h004;
   localparam logic [11:0] CID_OFS_FORCE   = 12'h008;
   localparam int          CID_ADDR_W      = 12;

   // Identification word field positions
   localparam int CID_EXT_BIT   = 31;
   localparam int CID_TYP_LSB   = 28;
   localparam int CID_ARCHITECTURE_CODE_LSB  = 20;
   localparam int CID_SRAM_LSB  = 16;
   localparam int CID_SIZ2_LSB  = 12;
   localparam int CID_SIZ1_LSB  = 8;
   localparam int CID_PROC_LSB  = 5;
   localparam int CID_REV_LSB   = 0;
   localparam int CID_FORCE_BIT = 0;

   // Program memory size encodings
   localparam logic [3:0] CID_SIZ_NONE  = 4'h0;
   localparam logic [3:0] CID_SIZ_8K    = 4'h1;
   localparam logic [3:0] CID_SIZ_16K   = 4'h2;
   localparam logic [3:0] CID_SIZ_32K   = 4'h3;
   localparam logic [3:0] CID_SIZ_64K   = 4'h5;
   localparam logic [3:0] CID_SIZ_128K  = 4'h7;
   localparam logic [3:0] CID_SIZ_256K  = 4'h9;
   localparam logic [3:0] CID_SIZ_512K  = 4'ha;
   localparam logic [3:0] CID_SIZ_1024K = 4'hc;
   localparam logic [3:0] CID_SIZ_2048K = 4'he;

   // SRAM size encodings
   localparam logic [3:0] CID_SRAM_RSVD = 4'h0;
   localparam logic [3:0] CID_SRAM_64K  = 4'hb;

   // Memory type encodings
   typedef enum logic [2:0] {
      CID_TYP_ROM      = 3'h0,
      CID_TYP_ROMLESS  = 3'h1,
      CID_TYP_FLASH    = 3'h2,
      CID_TYP_ROMFLASH = 3'h3,
      CID_TYP_SRAMEMU  = 3'h4
   } cid_memtype_t;

   localparam logic [31:0] CID_ZERO_WORD = 32'h0000_0000;

   // Read-data bus return for unmapped addresses
   localparam logic [31:0] CID_UNMAPPED  = 32'h0000_0000;

endpackage

// *** cid_size_check.sv ***
`timescale 1ns/1ps
// Decoder that flags reserved codes of a size field
module cid_size_check
   import cid_pkg::*;
#(
   parameter bit SRAM_TABLE = 1'b0
)
(
   input  wire logic [3:0] code_i,
   output logic            legal_o
);

   always_comb
   begin
      if (SRAM_TABLE)
         legal_o = (code_i != CID_SRAM_RSVD);
      else
      begin
         case (code_i)
            CID_SIZ_NONE, CID_SIZ_8K, CID_SIZ_16K, CID_SIZ_32K, CID_SIZ_64K,
            CID_SIZ_128K, CID_SIZ_256K, CID_SIZ_512K, CID_SIZ_1024K,
            CID_SIZ_2048K: legal_o = 1'b1;
            default:       legal_o = 1'b0;
         endcase
      end
   end

endmodule

// *** cid_tap_force.sv ***
`timescale 1ns/1ps
// Test-reset steering: follows power-on reset or is held low
module cid_tap_force
(
   input  wire logic CLOCK_I,
   input  wire logic RST_B_I,
   input  wire logic force_i,
   input  wire logic por_b_i,
   output logic      trst_b_o
);

   // Registered so the pin never glitches while the force bit changes
   always_ff @(posedge CLOCK_I or negedge RST_B_I)
   begin
      if (!RST_B_I)
         trst_b_o <= 1'b0;
      else
         trst_b_o <= force_i ? 1'b0 : por_b_i;
   end

endmodule

// *** cid_top.sv ***
// Design decisions made here: register access over APB and the placing of the registers.
`timescale 1ns/1ps
// Chip identification registers and test-reset force control on APB
// Operation
// - A 32-bit read-only ident word holds ext flag, type, architecture_code, SRAM, two sizes, cpu, rev.
// - Revision, processor and architecture codes are fixed product constants (5, 3 and 8 bits).
// - The first program memory size field uses the listed size code table with reserved gaps.
// - The second program memory size field uses the same code table as the first.
// - The SRAM size field uses its own 16-entry table where code 0 is reserved.
// - The memory type field codes ROM, ROMless, flash, ROM plus flash and SRAM-as-ROM.
// - The extension flag reads 1 only when an extension word is implemented.
// - The extension word is read-only and reads all zeros whenever the flag is 0.
// - A read-write force bit at bit 0, when 0, lets test-reset follow power-on reset.
// - When the force bit is 1, test-reset is held low for as long as it stays set.
module cid_top
   import cid_pkg::*;
#(
   parameter logic [4:0]  REVISION    = 5'h01,    // Arbitrary value
   parameter logic [2:0]  PROC_CODE   = 3'h1,     // Arbitrary value
   parameter logic [7:0]  ARCHITECTURE_CODE_CODE   = 8'h0a,    // Arbitrary value
   parameter logic [2:0]  MEM_TYPE    = CID_TYP_ROMFLASH,
   parameter logic [3:0]  SIZE_FIRST  = CID_SIZ_32K,
   parameter logic [3:0]  SIZE_SECOND = CID_SIZ_256K,
   parameter logic [3:0]  SRAM_SIZE   = CID_SRAM_64K,
   parameter bit          HAS_EXT     = 1'b1,
   parameter logic [31:0] EXT_WORD    = 32'h0000_0a5a  // Arbitrary value
)
(
   input  wire logic                  CLOCK_I,
   input  wire logic                  RST_B_I,
   input  wire logic                  PSEL_I,
   input  wire logic                  PENABLE_I,
   input  wire logic                  PWRITE_I,
   input  wire logic [CID_ADDR_W-1:0] PADDR_I,
   input  wire logic [31:0]           PWDATA_I,
   input  wire logic                  POR_B_I,
   output logic [31:0]                PRDATA_O,
   output logic                       PREADY_O,
   output logic                       PSLVERR_O,
   output logic                       TRST_B_O,
   output logic                       CFG_LEGAL_O
);

   logic        force_test_reset;
   logic [31:0] chip_identification;
   logic [31:0] chip_identification_extension;
   logic        setup;
   logic        mapped;
   logic [31:0] next_rdata;
   logic        legal_siz1;
   logic        legal_siz2;
   logic        legal_sram;
   logic        legal_type;

   // Fixed identification word; constants only, so writes cannot touch it
   assign chip_identification =
      {HAS_EXT, MEM_TYPE, ARCHITECTURE_CODE_CODE, SRAM_SIZE, SIZE_SECOND, SIZE_FIRST,
       PROC_CODE, REVISION};

   assign chip_identification_extension = HAS_EXT ? EXT_WORD : CID_ZERO_WORD;

   cid_size_check #(.SRAM_TABLE(1'b0)) u_siz1
   (
      .code_i  (SIZE_FIRST),
      .legal_o (legal_siz1)
   );

   cid_size_check #(.SRAM_TABLE(1'b0)) u_siz2
   (
      .code_i  (SIZE_SECOND),
      .legal_o (legal_siz2)
   );

   cid_size_check #(.SRAM_TABLE(1'b1)) u_sram
   (
      .code_i  (SRAM_SIZE),
      .legal_o (legal_sram)
   );

   assign legal_type = (MEM_TYPE <= CID_TYP_SRAMEMU);

   // Zero-wait-state slave: access phase always completes at once
   assign setup  = PSEL_I && !PENABLE_I;
   assign mapped = (PADDR_I == CID_OFS_IDENT) || (PADDR_I == CID_OFS_EXTID)
                   || (PADDR_I == CID_OFS_FORCE);

   always_comb
   begin
      case (PADDR_I)
         CID_OFS_IDENT: next_rdata = chip_identification;
         CID_OFS_EXTID: next_rdata = chip_identification_extension;
         CID_OFS_FORCE: next_rdata = {31'h0000_0000, force_test_reset};
         default:       next_rdata = CID_UNMAPPED;
      endcase
   end

   // Answer prepared in setup so every output comes from a flip-flop
   always_ff @(posedge CLOCK_I or negedge RST_B_I)
   begin
      if (!RST_B_I)
      begin
         PREADY_O  <= 1'b0;
         PRDATA_O  <= CID_ZERO_WORD;
         PSLVERR_O <= 1'b0;
      end
      else
      begin
         PREADY_O  <= setup;
         PSLVERR_O <= setup && !mapped;
         if (setup && !PWRITE_I)
            PRDATA_O <= next_rdata;
         else if (!setup)
            PRDATA_O <= CID_ZERO_WORD;
      end
   end

   // Only the force bit is writable; ident writes fall through
   always_ff @(posedge CLOCK_I or negedge RST_B_I)
   begin
      if (!RST_B_I)
         force_test_reset <= 1'b0;
      else if (PSEL_I && PENABLE_I && PREADY_O && PWRITE_I
               && PADDR_I == CID_OFS_FORCE)
         force_test_reset <= PWDATA_I[CID_FORCE_BIT];
   end

   always_ff @(posedge CLOCK_I or negedge RST_B_I)
   begin
      if (!RST_B_I)
         CFG_LEGAL_O <= 1'b0;
      else
         CFG_LEGAL_O <= legal_siz1 && legal_siz2 && legal_sram && legal_type;
   end

   cid_tap_force u_force
   (
      .CLOCK_I  (CLOCK_I),
      .RST_B_I  (RST_B_I),
      .force_i  (force_test_reset),
      .por_b_i  (POR_B_I),
      .trst_b_o (TRST_B_O)
   );

   // Checks
   default clocking cb @(posedge CLOCK_I);
   endclocking
   default disable iff (!RST_B_I);

   ident_read_a: assert property (
      setup && !PWRITE_I && PADDR_I == CID_OFS_IDENT
      |=> PREADY_O && PRDATA_O[CID_EXT_BIT] == HAS_EXT
          && PRDATA_O[CID_ARCHITECTURE_CODE_LSB +: 8] == ARCHITECTURE_CODE_CODE)
      else $error("ident word read wrong");

   fixed_codes_a: assert property (
      setup && !PWRITE_I && PADDR_I == CID_OFS_IDENT
      |=> PRDATA_O[CID_PROC_LSB +: 3] == PROC_CODE
          && PRDATA_O[CID_REV_LSB +: 5] == REVISION)
      else $error("processor or revision code wrong");

   size_fields_a: assert property (
      setup && !PWRITE_I && PADDR_I == CID_OFS_IDENT
      |=> PRDATA_O[CID_SIZ1_LSB +: 4] == SIZE_FIRST
          && PRDATA_O[CID_SIZ2_LSB +: 4] == SIZE_SECOND)
      else $error("size fields wrong");

   sram_type_a: assert property (
      setup && !PWRITE_I && PADDR_I == CID_OFS_IDENT
      |=> PRDATA_O[CID_SRAM_LSB +: 4] == SRAM_SIZE
          && PRDATA_O[CID_TYP_LSB +: 3] == MEM_TYPE)
      else $error("sram or type field wrong");

   ext_zero_a: assert property (
      setup && !PWRITE_I && PADDR_I == CID_OFS_EXTID && !HAS_EXT
      |=> PRDATA_O == CID_ZERO_WORD)
      else $error("extension word not zero");

   force_follow_a: assert property (
      !force_test_reset |=> TRST_B_O == $past(POR_B_I))
      else $error("test reset not following power-on reset");

   force_hold_a: assert property (
      force_test_reset [*2] |-> !TRST_B_O)
      else $error("test reset not held low");

   force_unused_a: assert property (
      setup && !PWRITE_I && PADDR_I == CID_OFS_FORCE
      |=> PRDATA_O[31:1] == 31'h0000_0000 && PRDATA_O[0] == force_test_reset)
      else $error("force register read wrong");

   force_write_c: cover property (
      PSEL_I && PENABLE_I && PWRITE_I && PADDR_I == CID_OFS_FORCE ##1 force_test_reset);
   ident_read_c: cover property (
      PSEL_I && PENABLE_I && !PWRITE_I && PADDR_I == CID_OFS_IDENT);
   unmapped_c: cover property (PSLVERR_O);

endmodule

// *** cid_top_bench.sv ***
`timescale 1ns/1ps
// Self-checking bench for the chip identity and test-reset force block
module cid_top_bench
   import cid_pkg::*;
;
   localparam int          REV  = 11;
   localparam int          PRC  = 6;
   localparam int          ARC  = 92;  // Arbitrary value
   localparam logic [31:0] EXTW = 32'h00c3_1e77;  // Arbitrary value
   localparam logic [2:0]  TYP_A  = CID_TYP_ROMFLASH;
   localparam logic [2:0]  TYP_B  = CID_TYP_SRAMEMU;
   localparam logic [3:0]  SIZ1_A = CID_SIZ_32K;
   localparam logic [3:0]  SIZ1_B = 4'h4;  // Reserved code on purpose
   localparam logic [3:0]  SIZ2   = CID_SIZ_256K;
   localparam logic [3:0]  SRAMS  = CID_SRAM_64K;
   localparam bit          EXT_A  = 1'b1;
   localparam bit          EXT_B  = 1'b0;
   logic        clk, rst_b, psel, penable, pwrite, por_b;
   logic [11:0] paddr;
   logic [31:0] pwdata, rdata_a, rdata_b, rd_a, rd_b;
   logic        ready_a, ready_b, err_a, err_b, er_a, trst_a, trst_b, legal_a, legal_b;
   int          n_mismatch, checks_done, force_m;

   // Second copy: no extension, reserved first size code
   cid_top #(.REVISION(5'(REV)), .PROC_CODE(3'(PRC)), .ARCHITECTURE_CODE_CODE(8'(ARC)), .MEM_TYPE(TYP_A),
      .SIZE_FIRST(SIZ1_A), .SIZE_SECOND(SIZ2), .SRAM_SIZE(SRAMS), .HAS_EXT(EXT_A),
      .EXT_WORD(EXTW))
   cid_top_inst (.CLOCK_I(clk), .RST_B_I(rst_b), .PSEL_I(psel), .PENABLE_I(penable),
      .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .POR_B_I(por_b),
      .PRDATA_O(rdata_a), .PREADY_O(ready_a), .PSLVERR_O(err_a), .TRST_B_O(trst_a),
      .CFG_LEGAL_O(legal_a));
   cid_top #(.REVISION(5'(REV)), .PROC_CODE(3'(PRC)), .ARCHITECTURE_CODE_CODE(8'(ARC)), .MEM_TYPE(TYP_B),
      .SIZE_FIRST(SIZ1_B), .SIZE_SECOND(SIZ2), .SRAM_SIZE(SRAMS), .HAS_EXT(EXT_B),
      .EXT_WORD(EXTW))
   cid_top_inst2 (.CLOCK_I(clk), .RST_B_I(rst_b), .PSEL_I(psel), .PENABLE_I(penable),
      .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .POR_B_I(por_b),
      .PRDATA_O(rdata_b), .PREADY_O(ready_b), .PSLVERR_O(err_b), .TRST_B_O(trst_b),
      .CFG_LEGAL_O(legal_b));

   initial
   begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   function automatic logic [31:0] ident(int extension_flag, int typ, int s1);
      return 32'((extension_flag << CID_EXT_BIT) | (typ << CID_TYP_LSB) | (ARC << CID_ARCHITECTURE_CODE_LSB)
         | (11 << CID_SRAM_LSB) | (9 << CID_SIZ2_LSB) | (s1 << CID_SIZ1_LSB)
         | (PRC << CID_PROC_LSB) | REV);
   endfunction

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("unexpected %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic finish_test();
      $display("mismatches %0d checks %0d", n_mismatch, checks_done);
      if (n_mismatch == 0 && checks_done > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // Request held until ready_a is seen high at a rising edge, or for at most 8 edges
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end while (ready_a !== 1'b1 && n < 8);
      check("ready_a", 32'(ready_a), 32'h1);
      check("ready_b", 32'(ready_b), 32'h1);
      rd_a = rdata_a;
      rd_b = rdata_b;
      er_a = err_a;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // Test-reset lags the power-on level by one edge unless forced low
   task automatic trst_run(input int n);
      logic prev;
      prev = 1'b0;
      for (int k = 0; k < n; k++)
      begin
         @(posedge clk);
         if (k > 0)
         begin
            check("trst_a", 32'(trst_a), force_m ? 32'h0 : 32'(prev));
            check("trst_b", 32'(trst_b), force_m ? 32'h0 : 32'(prev));
         end
         prev = por_b;
         por_b <= 1'($urandom);
      end
   endtask

   initial
   begin
      repeat (4000) @(posedge clk);
      n_mismatch++;
      finish_test();
   end

   initial
   begin
      rst_b = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
      paddr = 12'h000; pwdata = 32'h0; por_b = 1'b1; force_m = 0;
      repeat (4) @(posedge clk);
      check("trst in reset", 32'(trst_a), 32'h0);
      rst_b <= 1'b1;
      void'($urandom(48));
      apb(1'b0, CID_OFS_IDENT, 32'h0);
      check("ident_a", rd_a, ident(1, 3, 3));
      check("ident_b", rd_b, ident(0, 4, 4));
      check("legal_a", 32'(legal_a), 32'h1);
      check("legal_b", 32'(legal_b), 32'h0);
      for (int i = 0; i < 2; i++)
      begin
         apb(1'b1, i ? CID_OFS_EXTID : CID_OFS_IDENT, $urandom);
         check("wr err", 32'(er_a), 32'h0);
         apb(1'b0, i ? CID_OFS_EXTID : CID_OFS_IDENT, 32'h0);
         check("ro_a", rd_a, i ? EXTW : ident(1, 3, 3));
         check("ro_b", rd_b, i ? 32'h0 : ident(0, 4, 4));
      end
      trst_run(10);
      apb(1'b1, CID_OFS_FORCE, $urandom | 32'h1);
      force_m = 1;
      apb(1'b0, CID_OFS_FORCE, 32'h0);
      check("force rd", rd_a, 32'h1);
      trst_run(12);
      apb(1'b1, CID_OFS_FORCE, $urandom & 32'hffff_fffe);
      force_m = 0;
      apb(1'b0, CID_OFS_FORCE, 32'h0);
      check("force rd", rd_a, 32'h0);
      trst_run(10);
      apb(1'b1, 12'h00c, $urandom);
      check("unmapped err", 32'(er_a), 32'h1);
      apb(1'b0, 12'h00c, 32'h0);
      check("unmapped err", 32'(er_a), 32'h1);
      check("unmapped rd", rd_a, 32'h0);
      apb(1'b1, CID_OFS_FORCE, 32'h1);
      @(posedge clk);
      rst_b <= 1'b0;
      repeat (2) @(posedge clk);
      check("trst in reset", 32'(trst_a), 32'h0);
      rst_b <= 1'b1;
      apb(1'b0, CID_OFS_FORCE, 32'h0);
      check("force after reset", rd_a, 32'h0);
      finish_test();
   end
endmodule
